// *** tdo_pkg.sv ***
// Constants, opcodes and state encoding for the readout opcode handler
package tdo_pkg;

   // ==========================================================
   // Register map (byte offsets)
   localparam logic [3:0] ADR_CMD = 4'h0;
   localparam logic [3:0] ADR_STATUS = 4'h4;
   localparam int STATUS_WAIT_PARAM_BIT = 0;
   localparam int STATUS_RESULT_BIT = 1;

   // ==========================================================
   // Field layout
   localparam int WORD_W = 16;
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 8;
   localparam int DEAD_W = 2;
   localparam int LIMIT_W = 4;
   localparam int ERR_TYPES = 11;
   localparam int DEPTH_W = 3;
   localparam int HIT_CNT_W = 9;

   // ==========================================================
   // Opcodes (upper byte of the command word)
   localparam logic [7:0] OPC_SET_DEAD = 8'h28;
   localparam logic [7:0] OPC_RD_DEAD = 8'h29;
   localparam logic [7:0] OPC_HDR_ON = 8'h30;
   localparam logic [7:0] OPC_HDR_OFF = 8'h31;
   localparam logic [7:0] OPC_RD_HDR = 8'h32;
   localparam logic [7:0] OPC_SET_LIMIT = 8'h33;
   localparam logic [7:0] OPC_RD_LIMIT = 8'h34;
   localparam logic [7:0] OPC_MARK_ON = 8'h35;
   localparam logic [7:0] OPC_MARK_OFF = 8'h36;
   localparam logic [7:0] OPC_BYP_ON = 8'h37;
   localparam logic [7:0] OPC_BYP_OFF = 8'h38;
   localparam logic [7:0] OPC_SET_MASK = 8'h39;
   localparam logic [7:0] OPC_RD_MASK = 8'h3a;
   localparam logic [7:0] OPC_SET_DEPTH = 8'h3b;
   localparam logic [7:0] OPC_RD_DEPTH = 8'h3c;

   // ==========================================================
   // Reset values
   localparam logic [DEAD_W-1:0] RST_DEAD = 2'h0;
   localparam logic RST_HDR = 1'b0;
   localparam logic [LIMIT_W-1:0] RST_LIMIT = 4'h9;
   localparam logic RST_MARK = 1'b1;
   localparam logic RST_BYP = 1'b0;
   localparam logic [ERR_TYPES-1:0] RST_MASK = 11'h7ff;
   localparam logic [DEPTH_W-1:0] RST_DEPTH = 3'h7;

   // ==========================================================
   // Hit limit encoding
   localparam logic [LIMIT_W-1:0] LIMIT_ZERO = 4'h0;
   localparam logic [LIMIT_W-1:0] LIMIT_MAX_CODE = 4'h8;
   localparam logic [WORD_W-1:0] SIZE_ERR_FLAG = 16'h1000;

   // ==========================================================
   // Command state, Gray coded
   typedef enum logic [1:0] {
      TDO_IDLE = 2'b00,
      TDO_WAIT_PARAM = 2'b01,
      TDO_WAIT_READ = 2'b11
   } tdo_state_t;

endpackage

// *** tdo_opcode_handler.sv ***
// Command interpreter for converter readout configuration opcodes
`timescale 1ns/1ps
module tdo_opcode_handler #(
   parameter int ADR_W = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic trig_match_i,
   input wire logic evt_start_i,
   input wire logic hit_i,
   input wire logic evt_end_i,
   input wire logic [tdo_pkg::ERR_TYPES-1:0] err_type_i,
   output logic [tdo_pkg::DEAD_W-1:0] dead_time_o,
   output logic hdr_trl_en_o,
   output logic [tdo_pkg::LIMIT_W-1:0] hit_limit_o,
   output logic err_mark_en_o,
   output logic bypass_en_o,
   output logic [tdo_pkg::ERR_TYPES-1:0] err_mask_o,
   output logic [tdo_pkg::DEPTH_W-1:0] buf_depth_o,
   output logic [8:0] buf_words_o,
   output logic global_err_o,
   output logic err_mark_o,
   output logic bypass_o,
   output logic header_o,
   output logic hit_pass_o,
   output logic err_word_valid_o,
   output logic [tdo_pkg::WORD_W-1:0] err_word_o,
   output logic trailer_o
);

   // ==========================================================
   // Parameter check
   generate
      if (ADR_W < 4) begin : g_bad_adr
         $error("ADR_W too small for the register map");
      end
      if (tdo_pkg::ERR_TYPES > tdo_pkg::WORD_W) begin : g_bad_mask
         $error("Error mask wider than the command word");
      end
   endgenerate

   // ==========================================================
   // Bus decode
   wire logic bus_req;
   wire logic bus_wr;
   wire logic bus_rd;
   wire logic sel_cmd;
   wire logic sel_status;
   wire logic lanes_ok;
   wire logic cmd_wr;
   wire logic cmd_rd;
   wire logic [tdo_pkg::WORD_W-1:0] wr_word;
   wire logic [7:0] opcode;

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i;
   assign bus_rd = bus_req & ~wb_we_i;
   assign sel_cmd = wb_adr_i[3:0] == tdo_pkg::ADR_CMD;
   assign sel_status = wb_adr_i[3:0] == tdo_pkg::ADR_STATUS;
   assign lanes_ok = &wb_sel_i[1:0];
   assign cmd_wr = bus_wr & sel_cmd & lanes_ok;
   assign cmd_rd = bus_rd & sel_cmd;
   assign wr_word = wb_dat_i[tdo_pkg::WORD_W-1:0];
   assign opcode = wr_word[tdo_pkg::OPC_HI:tdo_pkg::OPC_LO];

   // ==========================================================
   // Opcode classes
   wire logic opc_param;
   wire logic opc_read;
   wire logic in_idle;

   assign opc_param = opcode == tdo_pkg::OPC_SET_DEAD || opcode == tdo_pkg::OPC_SET_LIMIT
      || opcode == tdo_pkg::OPC_SET_MASK || opcode == tdo_pkg::OPC_SET_DEPTH;
   assign opc_read = opcode == tdo_pkg::OPC_RD_DEAD || opcode == tdo_pkg::OPC_RD_HDR
      || opcode == tdo_pkg::OPC_RD_LIMIT || opcode == tdo_pkg::OPC_RD_MASK
      || opcode == tdo_pkg::OPC_RD_DEPTH;

   tdo_pkg::tdo_state_t state;
   tdo_pkg::tdo_state_t next_state;
   logic [7:0] pend_opc;
   logic [tdo_pkg::WORD_W-1:0] result;
   logic [tdo_pkg::WORD_W-1:0] next_result;

   assign in_idle = state == tdo_pkg::TDO_IDLE;

   // ==========================================================
   // Result word for read opcodes
   always_comb begin
      next_result = '0;
      case (opcode)
         tdo_pkg::OPC_RD_DEAD: begin
            next_result[tdo_pkg::DEAD_W-1:0] = dead_time_o;
         end
         tdo_pkg::OPC_RD_HDR: begin
            next_result[0] = hdr_trl_en_o;
         end
         tdo_pkg::OPC_RD_LIMIT: begin
            next_result[tdo_pkg::LIMIT_W-1:0] = hit_limit_o;
         end
         tdo_pkg::OPC_RD_MASK: begin
            next_result[tdo_pkg::ERR_TYPES-1:0] = err_mask_o;
         end
         tdo_pkg::OPC_RD_DEPTH: begin
            next_result[tdo_pkg::DEPTH_W-1:0] = buf_depth_o;
         end
         default: begin
            next_result = '0;
         end
      endcase
   end

   // ==========================================================
   // Command state machine
   always_comb begin
      next_state = state;
      case (state)
         tdo_pkg::TDO_IDLE: begin
            if (cmd_wr && opc_param) begin
               next_state = tdo_pkg::TDO_WAIT_PARAM;
            end else if (cmd_wr && opc_read) begin
               next_state = tdo_pkg::TDO_WAIT_READ;
            end
         end
         tdo_pkg::TDO_WAIT_PARAM: begin
            if (cmd_wr) begin
               next_state = tdo_pkg::TDO_IDLE;
            end
         end
         tdo_pkg::TDO_WAIT_READ: begin
            if (cmd_rd) begin
               next_state = tdo_pkg::TDO_IDLE;
            end
         end
         default: begin
            next_state = tdo_pkg::TDO_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= tdo_pkg::TDO_IDLE;
         pend_opc <= 8'h00;
         result <= '0;
      end else begin
         state <= next_state;
         if (in_idle && cmd_wr) begin
            pend_opc <= opcode;
         end
         if (in_idle && cmd_wr && opc_read) begin
            result <= next_result;
         end
      end
   end

   // ==========================================================
   // Settings
   wire logic param_wr;
   wire logic imm_wr;

   assign param_wr = cmd_wr && state == tdo_pkg::TDO_WAIT_PARAM;
   assign imm_wr = cmd_wr && in_idle;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dead_time_o <= tdo_pkg::RST_DEAD;
         hdr_trl_en_o <= tdo_pkg::RST_HDR;
         hit_limit_o <= tdo_pkg::RST_LIMIT;
         err_mark_en_o <= tdo_pkg::RST_MARK;
         bypass_en_o <= tdo_pkg::RST_BYP;
         err_mask_o <= tdo_pkg::RST_MASK;
         buf_depth_o <= tdo_pkg::RST_DEPTH;
      end else begin
         if (param_wr) begin
            case (pend_opc)
               tdo_pkg::OPC_SET_DEAD: begin
                  dead_time_o <= wr_word[tdo_pkg::DEAD_W-1:0];
               end
               tdo_pkg::OPC_SET_LIMIT: begin
                  hit_limit_o <= wr_word[tdo_pkg::LIMIT_W-1:0];
               end
               tdo_pkg::OPC_SET_MASK: begin
                  err_mask_o <= wr_word[tdo_pkg::ERR_TYPES-1:0];
               end
               tdo_pkg::OPC_SET_DEPTH: begin
                  buf_depth_o <= wr_word[tdo_pkg::DEPTH_W-1:0];
               end
               default: begin
                  dead_time_o <= dead_time_o;
               end
            endcase
         end
         if (imm_wr) begin
            case (opcode)
               tdo_pkg::OPC_HDR_ON: begin
                  hdr_trl_en_o <= 1'b1;
               end
               tdo_pkg::OPC_HDR_OFF: begin
                  hdr_trl_en_o <= 1'b0;
               end
               tdo_pkg::OPC_MARK_ON: begin
                  err_mark_en_o <= 1'b1;
               end
               tdo_pkg::OPC_MARK_OFF: begin
                  err_mark_en_o <= 1'b0;
               end
               tdo_pkg::OPC_BYP_ON: begin
                  bypass_en_o <= 1'b1;
               end
               tdo_pkg::OPC_BYP_OFF: begin
                  bypass_en_o <= 1'b0;
               end
               default: begin
                  bypass_en_o <= bypass_en_o;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Bus answer
   logic [31:0] status_word;
   wire logic wait_param;
   wire logic wait_read;
   wire logic [31:0] cmd_word;
   wire logic [31:0] next_dat;

   assign wait_param = state == tdo_pkg::TDO_WAIT_PARAM;
   assign wait_read = state == tdo_pkg::TDO_WAIT_READ;

   always_comb begin
      status_word = 32'h00000000;
      status_word[tdo_pkg::STATUS_WAIT_PARAM_BIT] = wait_param;
      status_word[tdo_pkg::STATUS_RESULT_BIT] = wait_read;
   end
   assign cmd_word = state == tdo_pkg::TDO_WAIT_READ ? {16'h0000, result} : 32'h00000000;
   assign next_dat = sel_cmd ? cmd_word : (sel_status ? status_word : 32'h00000000);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_rd) begin
            wb_dat_o <= next_dat;
         end
      end
   end

   // ==========================================================
   // Global error from enabled types
   wire logic [tdo_pkg::ERR_TYPES-1:0] err_hit;

   genvar gi;
   generate
      for (gi = 0; gi < tdo_pkg::ERR_TYPES; gi++) begin : g_err
         assign err_hit[gi] = err_type_i[gi] & err_mask_o[gi];
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         global_err_o <= 1'b0;
         err_mark_o <= 1'b0;
         bypass_o <= 1'b0;
      end else begin
         global_err_o <= |err_hit;
         err_mark_o <= (|err_hit) & err_mark_en_o;
         bypass_o <= (|err_hit) & bypass_en_o;
      end
   end

   // ==========================================================
   // Buffer depth in words
   localparam logic [8:0] BUF_WORDS_MIN = 9'h002;
   localparam logic [8:0] BUF_WORDS_RST = BUF_WORDS_MIN << tdo_pkg::RST_DEPTH;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buf_words_o <= BUF_WORDS_RST;
      end else begin
         buf_words_o <= BUF_WORDS_MIN << buf_depth_o;
      end
   end

   // ==========================================================
   // Event composition in trigger matching mode
   logic [tdo_pkg::HIT_CNT_W-1:0] hit_cnt;
   logic over;
   logic trl_pend;
   wire logic limited;
   wire logic [tdo_pkg::HIT_CNT_W-1:0] limit_val;
   wire logic hit_ok;
   wire logic tm_hit;

   assign limited = hit_limit_o <= tdo_pkg::LIMIT_MAX_CODE;
   assign limit_val = hit_limit_o == tdo_pkg::LIMIT_ZERO ? 9'h000
      : 9'h001 << (hit_limit_o - 4'h1);
   assign hit_ok = ~limited || hit_cnt < limit_val;
   assign tm_hit = trig_match_i & hit_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hit_cnt <= '0;
         over <= 1'b0;
         trl_pend <= 1'b0;
         header_o <= 1'b0;
         hit_pass_o <= 1'b0;
         err_word_valid_o <= 1'b0;
         err_word_o <= 16'h0000;
         trailer_o <= 1'b0;
      end else begin
         header_o <= trig_match_i & evt_start_i & hdr_trl_en_o;
         hit_pass_o <= tm_hit & hit_ok;
         err_word_valid_o <= 1'b0;
         trailer_o <= trl_pend;
         trl_pend <= 1'b0;
         if (trig_match_i && evt_start_i) begin
            hit_cnt <= '0;
            over <= 1'b0;
         end else if (tm_hit) begin
            if (hit_ok) begin
               hit_cnt <= hit_cnt + 9'h001;
            end else begin
               over <= 1'b1;
            end
         end
         if (trig_match_i && evt_end_i) begin
            if (over || (tm_hit && !hit_ok)) begin
               err_word_valid_o <= 1'b1;
               err_word_o <= tdo_pkg::SIZE_ERR_FLAG;
               trl_pend <= hdr_trl_en_o;
            end else begin
               trailer_o <= hdr_trl_en_o;
            end
         end
      end
   end

endmodule

// *** tdo_sva.sv ***
// Assertion checker for the readout opcode handler ports
`timescale 1ns/1ps
module tdo_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic trig_match_i,
   input wire logic evt_start_i,
   input wire logic [10:0] err_type_i,
   input wire logic hdr_trl_en_o,
   input wire logic [3:0] hit_limit_o,
   input wire logic [10:0] err_mask_o,
   input wire logic [2:0] buf_depth_o,
   input wire logic [8:0] buf_words_o,
   input wire logic global_err_o,
   input wire logic err_mark_o,
   input wire logic bypass_o,
   input wire logic header_o,
   input wire logic err_word_valid_o,
   input wire logic [15:0] err_word_o,
   input wire logic trailer_o
);
   // =====
   // Bus, settings and event checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   a_ack_next: assert property (take |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_hdr_hold: assert property (!(take && wb_we_i) |=> $stable(hdr_trl_en_o))
      else $error("header setting moved without write");
   a_limit_hold: assert property (!(take && wb_we_i) |=> $stable(hit_limit_o))
      else $error("hit limit moved without write");
   a_buf_words: assert property (!$past(rst_i) |->
      buf_words_o == (9'h002 << $past(buf_depth_o)))
      else $error("buffer words do not follow depth code");
   a_glob_err: assert property (!$past(rst_i) |->
      global_err_o == |($past(err_type_i) & $past(err_mask_o)))
      else $error("global error not masked sum");
   a_mark_gate: assert property (err_mark_o || bypass_o |-> global_err_o)
      else $error("mark or bypass without global error");
   a_err_word: assert property (err_word_valid_o |-> err_word_o == 16'h1000)
      else $error("size error word wrong");
   a_trl_after: assert property (err_word_valid_o && hdr_trl_en_o |=> trailer_o)
      else $error("trailer not after error word");
   a_header_src: assert property (header_o |->
      $past(evt_start_i) && $past(trig_match_i) && $past(hdr_trl_en_o))
      else $error("header without cause");
endmodule

// *** tdo_host.sv ***
// Wishbone host model issuing configuration opcodes
`timescale 1ns/1ps
module tdo_host (
   input wire logic clk_i,
   input wire logic wb_ack_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [3:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o
);
   // =====
   // Classic cycle held until ack
   task automatic xfer(input logic we, input logic [3:0] a, input logic [15:0] d,
      input logic [3:0] s, output logic [15:0] q);
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= a;
      wb_sel_o <= s;
      wb_dat_o <= {16'h0000, d};
      @(posedge clk_i);
      while (wb_ack_i !== 1'b1) @(posedge clk_i);
      q = wb_dat_i[15:0];
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_dat_o <= ~wb_dat_o;
   endtask
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 4'h0;
      wb_sel_o = 4'hf;
      wb_dat_o = 32'h0000_0000;
   end
endmodule

// *** tdo_opcode_handler_bench.sv ***
// Self-checking bench for the readout opcode handler
`timescale 1ns/1ps
module tdo_opcode_handler_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic trig_match_i = 1'b0;
   logic evt_start_i = 1'b0;
   logic hit_i = 1'b0;
   logic evt_end_i = 1'b0;
   logic [10:0] err_type_i = 11'h000;
   logic [1:0] dead_time_o;
   logic hdr_trl_en_o, err_mark_en_o, bypass_en_o, global_err_o, err_mark_o, bypass_o;
   logic header_o, hit_pass_o, err_word_valid_o, trailer_o;
   logic [3:0] hit_limit_o;
   logic [10:0] err_mask_o;
   logic [2:0] buf_depth_o;
   logic [8:0] buf_words_o;
   logic [15:0] err_word_o, q;
   int failures = 0;
   int check_count = 0;
   int nh = 0, np = 0, ne = 0, nt = 0;
   logic [7:0] rop [5] = '{8'h29, 8'h32, 8'h34, 8'h3a, 8'h3c};
   logic [15:0] rex [5] = '{16'h0000, 16'h0000, 16'h0009, 16'h07ff, 16'h0007};
   logic [7:0] sop [4] = '{8'h28, 8'h33, 8'h39, 8'h3b};
   int smap [4] = '{0, 2, 3, 4};
   logic [15:0] spa [4] = '{16'hfff3, 16'h0002, 16'h0555, 16'h0002};
   logic [15:0] sex [4] = '{16'h0003, 16'h0002, 16'h0555, 16'h0002};
   logic [7:0] pop [7] = '{8'h36, 8'h37, 8'h38, 8'h35, 8'h31, 8'h30, 8'h37};
   logic [2:0] pex [7] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h2, 3'h6, 3'h7};
   always #5 clk_i = ~clk_i;
   tdo_opcode_handler dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .trig_match_i, .evt_start_i, .hit_i,
      .evt_end_i, .err_type_i, .dead_time_o, .hdr_trl_en_o, .hit_limit_o, .err_mark_en_o,
      .bypass_en_o, .err_mask_o, .buf_depth_o, .buf_words_o, .global_err_o, .err_mark_o,
      .bypass_o, .header_o, .hit_pass_o, .err_word_valid_o, .err_word_o, .trailer_o);
   tdo_host host (.clk_i, .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
      .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
      .wb_dat_o(wb_dat_i));
   // =====
   // Event pulse counters
   always @(posedge clk_i) begin
      if (header_o === 1'b1) nh++;
      if (hit_pass_o === 1'b1) np++;
      if (err_word_valid_o === 1'b1) ne++;
      if (trailer_o === 1'b1) nt++;
   end
   // =====
   // Access tasks
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic [15:0] r;
      host.xfer(1'b1, a, d, 4'hf, r);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] r);
      host.xfer(1'b0, a, 16'h0000, 4'hf, r);
   endtask
   task automatic rdop(input logic [7:0] op, input logic [15:0] e);
      logic [15:0] r;
      wr(tdo_pkg::ADR_CMD, {op, 8'ha5});
      rd(tdo_pkg::ADR_CMD, r);
      chk(r, e);
   endtask
   task automatic ev(input logic [2:0] v);
      @(posedge clk_i);
      {evt_start_i, hit_i, evt_end_i} <= v;
      @(posedge clk_i);
      {evt_start_i, hit_i, evt_end_i} <= 3'h0;
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // =====
   // Test sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      trig_match_i <= 1'b1;
      @(posedge clk_i);
      chk(16'(buf_words_o), 16'h0100);
      chk(16'({hdr_trl_en_o, err_mark_en_o, bypass_en_o}), 16'h0002);
      for (int i = 0; i < 5; i++) rdop(rop[i], rex[i]);
      for (int i = 0; i < 4; i++) begin
         wr(tdo_pkg::ADR_CMD, {sop[i], 8'hc3});
         wr(tdo_pkg::ADR_CMD, spa[i]);
         rdop(rop[smap[i]], sex[i]);
      end
      chk(16'(buf_words_o), 16'h0008);
      rd(4'h8, q);
      chk(q, 16'h0000);
      wr(tdo_pkg::ADR_CMD, 16'h2800);
      rd(tdo_pkg::ADR_STATUS, q);
      chk(q, 16'h0001);
      wr(tdo_pkg::ADR_CMD, 16'h3002);
      chk(16'({hdr_trl_en_o, dead_time_o}), 16'h0002);
      wr(tdo_pkg::ADR_CMD, 16'h3200);
      wr(tdo_pkg::ADR_CMD, 16'h3000);
      rd(tdo_pkg::ADR_STATUS, q);
      chk(q, 16'h0002);
      rd(tdo_pkg::ADR_CMD, q);
      chk(q, 16'h0000);
      for (int i = 0; i < 7; i++) begin
         wr(tdo_pkg::ADR_CMD, {pop[i], 8'h00});
         chk(16'({hdr_trl_en_o, err_mark_en_o, bypass_en_o}), 16'(pex[i]));
      end
      rdop(8'h32, 16'h0001);
      host.xfer(1'b1, tdo_pkg::ADR_CMD, 16'h3100, 4'h2, q);
      chk(16'(hdr_trl_en_o), 16'h0001);
      ev(3'h4);
      repeat (3) ev(3'h2);
      ev(3'h1);
      repeat (4) @(posedge clk_i);
      chk({4'(nh), 4'(np), 4'(ne), 4'(nt)}, 16'h1211);
      err_type_i <= 11'h002;
      repeat (3) @(posedge clk_i);
      chk(16'(global_err_o), 16'h0000);
      err_type_i <= 11'h004;
      repeat (3) @(posedge clk_i);
      chk(16'({global_err_o, err_mark_o, bypass_o}), 16'h0007);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(16'({hdr_trl_en_o, err_mark_en_o, bypass_en_o}), 16'h0002);
      rdop(8'h29, 16'h0000);
      rdop(8'h34, 16'h0009);
      rdop(8'h3a, 16'h07ff);
      rdop(8'h3c, 16'h0007);
      print_verdict();
   end
   initial begin
      repeat (2000) @(posedge clk_i);
      failures++;
      print_verdict();
   end
endmodule
bind tdo_opcode_handler tdo_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_ack_o, .trig_match_i, .evt_start_i, .err_type_i, .hdr_trl_en_o, .hit_limit_o,
   .err_mask_o, .buf_depth_o, .buf_words_o, .global_err_o, .err_mark_o, .bypass_o,
   .header_o, .err_word_valid_o, .err_word_o, .trailer_o);
